// ==== src/oag_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts for the address generator
// Assumes: Included by its bare name from the core and the bench
// Notes:   Byte addresses on a 32-bit classic Wishbone bus
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OAG_OFF_CTRL 8'h00
`define OAG_OFF_POSTBYTE 8'h04
`define OAG_OFF_OPERAND 8'h08
`define OAG_OFF_PAGE 8'h0C
`define OAG_OFF_PTR0 8'h10
`define OAG_OFF_PC 8'h20
`define OAG_OFF_ACC 8'h24
`define OAG_OFF_STATUS 8'h28
`define OAG_OFF_OA 8'h2C
`define OAG_OFF_STORE 8'h30

// ****************************************
// Field positions
// ****************************************
`define OAG_CTRL_START 0
`define OAG_CTRL_MODE_LO 1
`define OAG_CTRL_STORE_SAME 3
`define OAG_ST_BUSY 0
`define OAG_ST_DONE 1
`define OAG_ST_UNDEF 2
`define OAG_ST_CYC_LO 8
`define OAG_ST_BYTES_LO 12

// ****************************************
// Reset values and fixed codes
// ****************************************
`define OAG_PAGE_RST 8'h00
`define OAG_EXT_IND_CODE 8'h9F
`define OAG_IND_EXTRA 4'h3
`define OAG_EXT_IND_CYC 4'h5

`endif

// ==== src/oag_pkg.sv ====
// Purpose: Types shared by the address generator
// Assumes: Nothing beyond the constants header
// Notes:   Binary state codes written out
package oag_pkg;
    typedef enum logic [2:0] {
        OAG_IDLE = 3'b000,
        OAG_CALC = 3'b001,
        OAG_RDHI = 3'b010,
        OAG_RDLO = 3'b011
    } oag_state_e;

    typedef enum logic [1:0] {
        OAG_MODE_DIRECT = 2'b00,
        OAG_MODE_EXTENDED = 2'b01,
        OAG_MODE_INDEXED = 2'b10
    } oag_mode_e;

    typedef logic [15:0] oag_word_t;
endpackage : oag_pkg

// ==== src/oag_core.sv ====
// Purpose: Operand address generator with a classic Wishbone register slave
// Assumes: Memory byte port on the same clock; software loads the register set
// Notes:   One request at a time; results stay until the next start
//
// Overview of operation
// RULE1 - Extended mode: operand word is absolute address
// RULE2 - Postbyte 9F: operand word points to address
// RULE3 - Direct: page base high, operand byte low
// RULE4 - Reset clears page base register
// RULE5 - Bit7 clear: add signed five-bit offset
// RULE6 - Bits 6:5 pick X, Y, U, S
// RULE7 - Bit4 with bit7 set selects indirection
// RULE8 - Post-increment pointer by one or two
// RULE9 - Pre-decrement pointer by one or two
// RULE10 - Zero offset: pointer used unchanged
// RULE11 - Signed 8/16-bit constant offset, pointer kept
// RULE12 - Accumulator A, B or D offset
// RULE13 - Counter-relative 8/16-bit offset, pointer field ignored
// RULE14 - Indirect: read high byte then low
// RULE15 - No indirect inc/dec-by-one or 5-bit
// RULE16 - Extra cycle counts for direct indexing
// RULE17 - Indirect adds three; extended indirect five
// RULE18 - Temp holds address; store incremented pointer
// RULE19 - Undefined postbytes flagged, no state change
// RULE20 - Wrap modulo 65536, high byte first
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "oag_cfg.svh"

module oag_core (
    input wire logic clk_i,                 // System clock, 100 MHz
    input wire logic rst_i,                 // Synchronous reset, active high
    input wire logic wb_cyc_i,              // Wishbone cycle
    input wire logic wb_stb_i,              // Wishbone strobe
    input wire logic wb_we_i,               // Wishbone write enable
    input wire logic [7:0] wb_adr_i,        // Wishbone byte address
    input wire logic [3:0] wb_sel_i,        // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic [31:0] wb_dat_o,           // Wishbone read data
    output logic wb_ack_o,                  // Wishbone acknowledge
    output logic mem_stb_o,                 // Memory byte read request
    output oag_pkg::oag_word_t mem_adr_o,   // Memory byte address
    input wire logic [7:0] mem_dat_i,       // Memory byte read data
    input wire logic mem_ack_i,             // Memory read done
    output oag_pkg::oag_word_t oa_o,        // Final operand address
    output logic done_o                     // Result valid, level
);
    import oag_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    oag_state_e state_reg, state_next;
    oag_mode_e mode_reg;
    logic store_same_reg;
    logic [7:0] postbyte_reg;
    oag_word_t operand_reg;
    logic [7:0] page_base_register_reg;
    oag_word_t ptr_reg [4];
    oag_word_t pc_reg;
    oag_word_t acc_reg;
    oag_word_t oa_reg;
    oag_word_t temp_reg;
    oag_word_t store_reg;
    logic [7:0] hi_reg;
    logic done_reg, undef_reg;
    logic [3:0] cyc_reg;
    logic [1:0] bytes_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic bus_wr = bus_req & wb_we_i;
    wire logic idle = (state_reg == OAG_IDLE);
    wire logic [7:0] wr_lo = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
    wire logic wr_ctrl = bus_wr & wb_sel_i[0] & (wb_adr_i == `OAG_OFF_CTRL);
    wire logic start = wr_ctrl & wb_dat_i[`OAG_CTRL_START] & idle;
    wire logic wr_post = bus_wr & wb_sel_i[0] & idle & (wb_adr_i == `OAG_OFF_POSTBYTE);
    wire logic wr_oper = bus_wr & idle & (wb_adr_i == `OAG_OFF_OPERAND);
    wire logic wr_page = bus_wr & wb_sel_i[0] & idle & (wb_adr_i == `OAG_OFF_PAGE);
    wire logic wr_pc = bus_wr & idle & (wb_adr_i == `OAG_OFF_PC);
    wire logic wr_acc = bus_wr & idle & (wb_adr_i == `OAG_OFF_ACC);
    wire logic [7:0] oper_hi = wb_sel_i[1] ? wb_dat_i[15:8] : operand_reg[15:8];
    wire logic [7:0] oper_lo = wb_sel_i[0] ? wb_dat_i[7:0] : operand_reg[7:0];

    // ****************************************
    // Postbyte decode
    // ****************************************
    wire logic [1:0] rsel = postbyte_reg[6:5];                        // [RULE6]
    wire logic short_off = ~postbyte_reg[7];
    wire logic ind = postbyte_reg[7] & postbyte_reg[4];              // [RULE7]
    wire logic [3:0] code = postbyte_reg[3:0];
    wire oag_word_t base_ptr = ptr_reg[rsel];
    wire oag_word_t off5 = {{11{postbyte_reg[4]}}, postbyte_reg[4:0]}; // [RULE5]
    wire oag_word_t off8 = {{8{operand_reg[15]}}, operand_reg[15:8]};  // [RULE20]
    wire oag_word_t offa = {{8{acc_reg[15]}}, acc_reg[15:8]};
    wire oag_word_t offb = {{8{acc_reg[7]}}, acc_reg[7:0]};
    wire logic ext_ind = (postbyte_reg == `OAG_EXT_IND_CODE);        // [RULE2]
    wire logic pc_form = ~short_off & ((code == 4'hC) | (code == 4'hD)); // [RULE13]

    logic legal;
    oag_word_t idx_off;
    logic [3:0] idx_cyc;
    logic [1:0] idx_bytes;
    always_comb begin
        legal = 1'b1;
        idx_off = 16'h0000;
        idx_cyc = 4'h0;
        idx_bytes = 2'h0;
        if (short_off) begin
            idx_off = off5;
            idx_cyc = 4'h1;                                        // [RULE16]
        end else begin
            case (code)
                4'h0: begin
                    idx_cyc = 4'h2;                                // [RULE8]
                    legal = ~ind;                                  // [RULE15]
                end
                4'h1: idx_cyc = 4'h3;                              // [RULE8]
                4'h2: begin
                    idx_off = 16'hFFFF;                            // [RULE9]
                    idx_cyc = 4'h2;
                    legal = ~ind;                                  // [RULE15]
                end
                4'h3: begin
                    idx_off = 16'hFFFE;                            // [RULE9]
                    idx_cyc = 4'h3;
                end
                4'h4: idx_cyc = 4'h0;                              // [RULE10]
                4'h5: begin
                    idx_off = offb;                                // [RULE12]
                    idx_cyc = 4'h1;
                end
                4'h6: begin
                    idx_off = offa;                                // [RULE12]
                    idx_cyc = 4'h1;
                end
                4'h8, 4'hC: begin
                    idx_off = off8;                                // [RULE11] [RULE13]
                    idx_cyc = 4'h1;
                    idx_bytes = 2'h1;
                end
                4'h9: begin
                    idx_off = operand_reg;                         // [RULE11]
                    idx_cyc = 4'h4;
                    idx_bytes = 2'h2;
                end
                4'hB: begin
                    idx_off = acc_reg;                             // [RULE12]
                    idx_cyc = 4'h4;
                end
                4'hD: begin
                    idx_off = operand_reg;                         // [RULE13]
                    idx_cyc = 4'h5;
                    idx_bytes = 2'h2;
                end
                4'hF: begin
                    legal = ext_ind;                               // [RULE2] [RULE19]
                    idx_cyc = `OAG_EXT_IND_CYC;                    // [RULE17]
                    idx_bytes = 2'h2;
                end
                default: legal = 1'b0;                             // [RULE19]
            endcase
            if (ind && code != 4'hF) begin
                idx_cyc = idx_cyc + `OAG_IND_EXTRA;                // [RULE17]
            end
        end
    end

    // Post-increment uses the old value; pre-decrement uses the new one
    wire logic post_inc = ~short_off & (code[3:1] == 3'b000);
    wire logic pre_dec = ~short_off & (code[3:1] == 3'b001);
    wire oag_word_t inc_amt = {14'h0000, code[0] ? 2'h2 : 2'h1};
    wire oag_word_t sum = (pc_form ? pc_reg : base_ptr) + idx_off;  // [RULE20]
    wire oag_word_t idx_oa = post_inc ? base_ptr : sum;               // [RULE8] [RULE9]
    wire oag_word_t new_ptr = post_inc ? base_ptr + inc_amt : sum;
    wire logic ptr_upd = (mode_reg == OAG_MODE_INDEXED) & legal & (post_inc | pre_dec);

    oag_word_t calc_oa;
    always_comb begin
        case (mode_reg)
            OAG_MODE_DIRECT: calc_oa = {page_base_register_reg, operand_reg[15:8]}; // [RULE3]
            OAG_MODE_EXTENDED: calc_oa = operand_reg;                 // [RULE1]
            OAG_MODE_INDEXED: calc_oa = (code == 4'hF && !short_off) ? operand_reg : idx_oa;
            default: calc_oa = 16'h0000;
        endcase
    end
    wire logic need_ind = (mode_reg == OAG_MODE_INDEXED) & legal & ind; // [RULE14]

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OAG_IDLE: if (start) begin
                state_next = OAG_CALC;
            end
            OAG_CALC: state_next = need_ind ? OAG_RDHI : OAG_IDLE;
            OAG_RDHI: if (mem_ack_i) begin
                state_next = OAG_RDLO;
            end
            OAG_RDLO: if (mem_ack_i) begin
                state_next = OAG_IDLE;
            end
            default: state_next = OAG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= OAG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Pointer registers
    // ****************************************
    // Software may load a pointer only while idle, so the update never races
    for (genvar g = 0; g < 4; g++) begin : g_ptr
        wire logic sw_wr = bus_wr & idle & (wb_adr_i == (`OAG_OFF_PTR0 + 8'(4 * g)));
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ptr_reg[g] <= 16'h0000;
            end else if (sw_wr) begin
                ptr_reg[g] <= {oper_hi_of(wb_sel_i[1], wb_dat_i[15:8], ptr_reg[g][15:8]),
                               oper_hi_of(wb_sel_i[0], wb_dat_i[7:0], ptr_reg[g][7:0])};
            end else if (state_reg == OAG_CALC && ptr_upd && rsel == 2'(g)) begin
                ptr_reg[g] <= new_ptr;                             // [RULE8] [RULE9]
            end
        end
    end

    function automatic logic [7:0] oper_hi_of(input logic s, input logic [7:0] n,
                                              input logic [7:0] o);
        oper_hi_of = s ? n : o;
    endfunction : oper_hi_of

    // ****************************************
    // Programming registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_base_register_reg <= `OAG_PAGE_RST;               // [RULE4]
            mode_reg <= OAG_MODE_DIRECT;
            store_same_reg <= 1'b0;
            postbyte_reg <= 8'h00;
            operand_reg <= 16'h0000;
            pc_reg <= 16'h0000;
            acc_reg <= 16'h0000;
        end else begin
            if (wr_page) begin
                page_base_register_reg <= wr_lo;
            end
            if (start) begin
                mode_reg <= oag_mode_e'(wb_dat_i[`OAG_CTRL_MODE_LO +: 2]);
                store_same_reg <= wb_dat_i[`OAG_CTRL_STORE_SAME];
            end
            if (wr_post) begin
                postbyte_reg <= wr_lo;
            end
            if (wr_oper) begin
                operand_reg <= {oper_hi, oper_lo};                 // [RULE20]
            end
            if (wr_pc) begin
                pc_reg <= {oper_hi_of(wb_sel_i[1], wb_dat_i[15:8], pc_reg[15:8]),
                           oper_hi_of(wb_sel_i[0], wb_dat_i[7:0], pc_reg[7:0])};
            end
            if (wr_acc) begin
                acc_reg <= {oper_hi_of(wb_sel_i[1], wb_dat_i[15:8], acc_reg[15:8]),
                            oper_hi_of(wb_sel_i[0], wb_dat_i[7:0], acc_reg[7:0])};
            end
        end
    end

    // ****************************************
    // Result registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oa_reg <= 16'h0000;
            temp_reg <= 16'h0000;
            store_reg <= 16'h0000;
            hi_reg <= 8'h00;
            done_reg <= 1'b0;
            undef_reg <= 1'b0;
            cyc_reg <= 4'h0;
            bytes_reg <= 2'h0;
        end else begin
            if (start) begin
                done_reg <= 1'b0;
            end
            if (state_reg == OAG_CALC) begin
                temp_reg <= calc_oa;                               // [RULE18]
                undef_reg <= (mode_reg == OAG_MODE_INDEXED) & ~legal; // [RULE19]
                cyc_reg <= (mode_reg == OAG_MODE_INDEXED && legal) ? idx_cyc : 4'h0;
                bytes_reg <= (mode_reg == OAG_MODE_INDEXED && legal) ? idx_bytes : 2'h0;
                store_reg <= (store_same_reg && ptr_upd) ? new_ptr : base_ptr; // [RULE18]
                if (!need_ind) begin
                    oa_reg <= ((mode_reg == OAG_MODE_INDEXED) && !legal) ? 16'h0000 : calc_oa;
                    done_reg <= 1'b1;
                end
            end
            if (state_reg == OAG_RDHI && mem_ack_i) begin
                hi_reg <= mem_dat_i;                               // [RULE14]
            end
            if (state_reg == OAG_RDLO && mem_ack_i) begin
                oa_reg <= {hi_reg, mem_dat_i};                     // [RULE14]
                done_reg <= 1'b1;
            end
        end
    end

    assign mem_stb_o = (state_reg == OAG_RDHI) | (state_reg == OAG_RDLO);
    assign mem_adr_o = (state_reg == OAG_RDLO) ? temp_reg + 16'h0001 : temp_reg; // [RULE20]
    assign oa_o = oa_reg;
    assign done_o = done_reg;

    // ****************************************
    // Bus read path
    // ****************************************
    wire logic [31:0] status_word = {18'h0_0000, bytes_reg, cyc_reg, 5'h00, undef_reg,
                                     done_reg, ~idle};
    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            `OAG_OFF_CTRL: rd_mux = {28'h000_0000, store_same_reg, mode_reg, 1'b0};
            `OAG_OFF_POSTBYTE: rd_mux = {24'h00_0000, postbyte_reg};
            `OAG_OFF_OPERAND: rd_mux = {16'h0000, operand_reg};
            `OAG_OFF_PAGE: rd_mux = {24'h00_0000, page_base_register_reg};
            8'h10: rd_mux = {16'h0000, ptr_reg[0]};
            8'h14: rd_mux = {16'h0000, ptr_reg[1]};
            8'h18: rd_mux = {16'h0000, ptr_reg[2]};
            8'h1C: rd_mux = {16'h0000, ptr_reg[3]};
            `OAG_OFF_PC: rd_mux = {16'h0000, pc_reg};
            `OAG_OFF_ACC: rd_mux = {16'h0000, acc_reg};
            `OAG_OFF_STATUS: rd_mux = status_word;
            `OAG_OFF_OA: rd_mux = {16'h0000, oa_reg};
            `OAG_OFF_STORE: rd_mux = {16'h0000, store_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            rdat_reg <= (bus_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ****************************************
    // Checks
    // ****************************************
    AST_PAGE_RESET: assert property (@(posedge clk_i) rst_i |=>          // [RULE4]
        page_base_register_reg == 8'h00) else $error("page base not cleared");
    AST_DIRECT_OA: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        (state_reg == OAG_CALC && mode_reg == OAG_MODE_DIRECT) |=>
        oa_reg == {$past(page_base_register_reg), $past(operand_reg[15:8])})
        else $error("direct address wrong");
    AST_EXT_OA: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        (state_reg == OAG_CALC && mode_reg == OAG_MODE_EXTENDED) |=>
        oa_reg == $past(operand_reg) && done_reg) else $error("extended address wrong");
    AST_POSTINC: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        (state_reg == OAG_CALC && ptr_upd && post_inc) |=>
        ptr_reg[$past(rsel)] == $past(base_ptr) + $past(inc_amt)) else $error("post inc wrong");
    AST_PREDEC: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
        (state_reg == OAG_CALC && ptr_upd && pre_dec && !ind) |=>
        oa_reg == ptr_reg[$past(rsel)]) else $error("pre dec address wrong");
    AST_NO_IND_SHORT: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
        (state_reg == OAG_CALC && mode_reg == OAG_MODE_INDEXED && postbyte_reg[7] &&
         postbyte_reg[4] && code[3:1] == 3'b000 && !code[0]) |=> undef_reg && done_reg)
        else $error("indirect by one accepted");
    AST_IND_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
        (state_reg == OAG_CALC && need_ind) |=> mem_stb_o && mem_adr_o == $past(calc_oa))
        else $error("indirect read address wrong");
    AST_IND_OA: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
        (state_reg == OAG_RDLO && mem_ack_i) |=> oa_reg == {hi_reg, $past(mem_dat_i)}
        && done_reg) else $error("indirect result wrong");
    AST_IND_CYC: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
        (state_reg == OAG_CALC && need_ind && code == 4'h4) |=> cyc_reg == 4'h3)
        else $error("indirect cycle count wrong");
    AST_UNDEF_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE19]
        (state_reg == OAG_CALC && mode_reg == OAG_MODE_INDEXED && !legal) |=>
        ptr_reg[rsel] == $past(base_ptr)) else $error("undefined code changed pointer");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule : oag_core

// ==== test/oag_mem_model.sv ====
// Purpose: Memory byte port model that answers the generator's indirect reads
// Assumes: Same clock as the generator; one byte per acknowledge
// Notes:   The wait is 0 to 3 cycles, taken from the low address bits
`timescale 1ns/1ps
module oag_mem_model (
    input wire logic clk_i,            // System clock
    input wire logic rst_i,            // Synchronous reset
    input wire logic mem_stb_i,        // Read request from the generator
    input wire logic [15:0] mem_adr_i, // Byte address
    output logic [7:0] mem_dat_o,      // Byte returned
    output logic mem_ack_o             // One-cycle acknowledge
);
    logic [1:0] wait_reg;
    logic hit;
    assign hit = mem_stb_i && !mem_ack_o && wait_reg == mem_adr_i[1:0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_ack_o <= 1'b0;
            mem_dat_o <= 8'hA5;
            wait_reg <= 2'h0;
        end else begin
            mem_ack_o <= hit;
            // Outside the ack cycle the byte keeps moving, so a late sample shows
            mem_dat_o <= hit ? mem_adr_i[7:0] ^ mem_adr_i[15:8] ^ 8'h3C : ~mem_dat_o;
            wait_reg <= (mem_stb_i && !mem_ack_o && !hit) ? wait_reg + 2'h1 : 2'h0;
        end
    end
endmodule : oag_mem_model

// ==== test/operand_address_generator_bench.sv ====
// Purpose: Self-checking bench for the operand address generator
// Assumes: Memory model answers indirect reads; registers loaded over Wishbone
// Notes:   Every postbyte runs once with random registers, then random modes
`timescale 1ns/1ps
`include "oag_cfg.svh"
module operand_address_generator_bench;
    import oag_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, mem_stb_o, mem_ack_i, done_o;
    logic [7:0] mem_dat_i;
    logic [7:0] page = 8'h00;
    oag_word_t mem_adr_o, oa_o, pc, acc, opw;
    oag_word_t ptr [4];
    int err_count = 0;
    int n_compared = 0;
    int ticks = 0;
    localparam logic [3:0] CYT [16] = '{2, 3, 2, 3, 0, 1, 1, 0, 1, 4, 0, 4, 1, 5, 0, 0};
    localparam logic [1:0] BYT [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 0, 0, 1, 2, 0, 0};
    oag_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mem_stb_o(mem_stb_o), .mem_adr_o(mem_adr_o),
        .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .oa_o(oa_o), .done_o(done_o));
    oag_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_stb_i(mem_stb_o),
        .mem_adr_i(mem_adr_o), .mem_dat_o(mem_dat_i), .mem_ack_o(mem_ack_i));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 40000) begin
            err_count++;
            give_verdict();
        end
    end
    // ****************************************
    // Bus cycles, checks and expectations
    // ****************************************
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0000_0000, q);
    endtask : rd
    function automatic oag_word_t sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction : sx
    // High byte sits at the lower location
    function automatic oag_word_t mw(input oag_word_t a);
        oag_word_t b;
        b = a + 16'h0001;
        return {a[7:0] ^ a[15:8] ^ 8'h3C, b[7:0] ^ b[15:8] ^ 8'h3C};
    endfunction : mw
    task automatic run(input logic [1:0] md, input logic [7:0] pb, input logic rp);
        logic [31:0] q, st;
        logic [3:0] cd, cy;
        logic [1:0] by;
        logic ss, und;
        oag_word_t base, np, oa;
        ss = 1'($urandom);
        for (int i = 0; i < 4; i++) begin
            ptr[i] = 16'($urandom);
            wr(8'(`OAG_OFF_PTR0 + 4 * i), {16'h0000, ptr[i]});
        end
        pc = 16'($urandom);
        acc = 16'($urandom);
        opw = 16'($urandom);
        if (rp) page = 8'($urandom);
        wr(`OAG_OFF_PC, {16'h0000, pc});
        wr(`OAG_OFF_ACC, {16'h0000, acc});
        wr(`OAG_OFF_OPERAND, {16'h0000, opw});
        wr(`OAG_OFF_PAGE, {24'h00_0000, page});
        wr(`OAG_OFF_POSTBYTE, {24'h00_0000, pb});
        wr(`OAG_OFF_CTRL, {28'h000_0000, ss, md, 1'b1});
        do begin
            rd(`OAG_OFF_STATUS, st);
        end while (st[1] !== 1'b1);
        cd = pb[3:0];
        base = ptr[pb[6:5]];
        np = base;
        und = 1'b0;
        cy = 4'h0;
        by = 2'h0;
        if (md == OAG_MODE_DIRECT) oa = {page, opw[15:8]};
        else if (md == OAG_MODE_EXTENDED) oa = opw;
        else if (!pb[7]) begin
            oa = base + {{11{pb[4]}}, pb[4:0]};
            cy = 4'h1;
        end else if (pb == `OAG_EXT_IND_CODE) begin
            oa = mw(opw);
            cy = `OAG_EXT_IND_CYC;
            by = 2'h2;
        end else begin
            // Short offset and step-by-one have no indirect form
            und = cd == 4'h7 || cd == 4'hA || cd >= 4'hE || (pb[4] && !cd[0] && cd < 4'h4);
            if (cd < 4'h4) np = cd[1] ? base - 16'(cd[0] + 1) : base + 16'(cd[0] + 1);
            case (cd)
                4'h2, 4'h3: oa = np;
                4'h5: oa = base + sx(acc[7:0]);
                4'h6: oa = base + sx(acc[15:8]);
                4'h8: oa = base + sx(opw[15:8]);
                4'h9: oa = base + opw;
                4'hB: oa = base + acc;
                4'hC: oa = pc + sx(opw[15:8]);
                4'hD: oa = pc + opw;
                default: oa = base;
            endcase
            cy = und ? 4'h0 : CYT[cd] + (pb[4] ? `OAG_IND_EXTRA : 4'h0);
            by = und ? 2'h0 : BYT[cd];
            oa = und ? 16'h0000 : (pb[4] ? mw(oa) : oa);
            np = und ? base : np;
        end
        chk("done", {31'h0, done_o}, 32'h1);
        chk("status", st & 32'h0000_3F07, {18'h0, by, cy, 5'h0, und, 2'b10});
        rd(`OAG_OFF_OA, q);
        chk("oa reg", {16'h0, q[15:0]}, {16'h0, oa});
        chk("oa port", {16'h0, oa_o}, {16'h0, oa});
        rd(8'(`OAG_OFF_PTR0 + 4 * pb[6:5]), q);
        chk("pointer", {16'h0, q[15:0]}, {16'h0, np});
        rd(`OAG_OFF_STORE, q);
        if (md == OAG_MODE_INDEXED) chk("store", {16'h0, q[15:0]}, {16'h0, ss ? np : base});
    endtask : run
    initial begin
        logic [31:0] q;
        q = $urandom(36849);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`OAG_OFF_PAGE, q);
        chk("page reset", q, 32'h0000_0000);
        run(OAG_MODE_DIRECT, 8'h00, 1'b0);
        rd(8'h3C, q);
        chk("unmapped", q, 32'h0000_0000);
        for (int i = 0; i < 256; i++) begin
            run(OAG_MODE_INDEXED, 8'(i), 1'b1);
        end
        repeat (40) begin
            run(2'($urandom_range(2, 0)), 8'($urandom), 1'b1);
        end
        give_verdict();
    end
endmodule : operand_address_generator_bench
